// [rpm_pkg.sv]
// Package of constants and state types for the ring pulse period meter.
`default_nettype none

package rpm_pkg;

    // ------------------------------------------------------------------
    // Clock and measurement tick rates.
    // ------------------------------------------------------------------
    // System clock rate in hertz.
    localparam int unsigned CLK_HZ = 100_000_000;
    // Finest tick rate in hertz; coarser rates divide it by 2, 4 and 8.
    localparam int unsigned TICK_FINE_HZ = 96_000;
    // System clock cycles per finest tick, rounded down.
    localparam int unsigned TICK_FINE_CYCLES = CLK_HZ / TICK_FINE_HZ;
    // Width of the finest-tick divider counter.
    localparam int unsigned TICK_DIV_W = 12;

    // ------------------------------------------------------------------
    // Register indices; the APB byte address is four times the index.
    // ------------------------------------------------------------------
    localparam logic [9:0] IDX_CONTROL = 10'h1b0;
    localparam logic [9:0] IDX_LEVEL = 10'h1b1;
    localparam logic [9:0] IDX_RESULT = 10'h1b2;
    localparam logic [9:0] IDX_HOLD = 10'h1b4;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h1b5;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h1b6;

    // ------------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------------
    localparam int unsigned CTRL_SEL_LSB = 0;
    localparam int unsigned CTRL_RES_LSB = 2;
    localparam int unsigned CTRL_EN_BIT = 7;
    localparam int unsigned HOLD_BIT = 0;
    localparam int unsigned LEVEL_BIT = 0;
    localparam int unsigned IRQ_EVENT_BIT = 0;

    // ------------------------------------------------------------------
    // Reset values and limits.
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] HOLD_RESET = 8'h00;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    // Whole state of the meter core.
    typedef struct packed {
        logic enable;          // Ring detection enable.
        logic [1:0] res;       // Tick resolution code.
        logic [1:0] sel;       // Edge select: bit 0 falling, bit 1 rising.
        logic hold;            // Hold mode for the result register.
        logic armed;           // Next event may capture while holding.
        logic [15:0] count;    // Saturating interval counter.
        logic [15:0] result;   // Captured interval.
        logic status;          // Sticky event flag.
        logic mask;            // Interrupt enable for the event flag.
        logic level_prev;      // Level one cycle ago, for edge detection.
        logic [31:0] prdata;   // Registered read data.
    } rpm_state_s;

    localparam rpm_state_s STATE_RESET = '{
        enable: CTRL_RESET[CTRL_EN_BIT],
        res: CTRL_RESET[CTRL_RES_LSB +: 2],
        sel: CTRL_RESET[CTRL_SEL_LSB +: 2],
        hold: HOLD_RESET[HOLD_BIT],
        armed: 1'b1,
        count: RESULT_RESET,
        result: RESULT_RESET,
        status: 1'b0,
        mask: 1'b0,
        level_prev: 1'b0,
        prdata: RDATA_RESET
    };

    // State of the tick divider.
    typedef struct packed {
        logic [TICK_DIV_W-1:0] base;  // Cycles within one finest tick.
        logic [2:0] sub;              // Finest ticks, for the coarser rates.
    } rpm_tick_s;

    // State of the two-stage synchroniser.
    typedef struct packed {
        logic first;   // First stage, read only by the second.
        logic second;  // Second stage, safe to use.
    } rpm_sync_s;

    // Word index of an APB byte address.
    function automatic logic [9:0] reg_index(input logic [11:0] addr);
        reg_index = addr[11:2];
    endfunction : reg_index

    // True when the address names one of the registers.
    function automatic logic reg_mapped(input logic [11:0] addr);
        logic [9:0] idx;
        idx = addr[11:2];
        reg_mapped = (addr[1:0] == 2'h0) &&
            ((idx == IDX_CONTROL) || (idx == IDX_LEVEL) || (idx == IDX_RESULT) ||
             (idx == IDX_HOLD) || (idx == IDX_IRQ_STATUS) || (idx == IDX_IRQ_MASK));
    endfunction : reg_mapped

endpackage : rpm_pkg

`default_nettype wire

// [rpm_sync.sv]
// Two-stage synchroniser for the asynchronous ring input.
`default_nettype none

module rpm_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic async_in,
    output logic sync_out
);

    // ------------------------------------------------------------------
    // State.
    // ------------------------------------------------------------------
    rpm_pkg::rpm_sync_s st_reg;   // Both stages.
    rpm_pkg::rpm_sync_s st_next;  // Next value of both stages.

    // The first stage may go metastable, so only the second stage reads it.
    always_comb begin
        st_next.first = async_in;
        st_next.second = st_reg.first;
    end

    // Both stages clear at reset.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sync_out = st_reg.second;

endmodule : rpm_sync

`default_nettype wire

// [rpm_tick_gen.sv]
// Measurement tick generator: one-cycle enables at four selectable rates.
`default_nettype none

module rpm_tick_gen #(
    parameter int unsigned BASE_DIV = rpm_pkg::TICK_FINE_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] res,
    output logic tick
);

    // ------------------------------------------------------------------
    // State and decode.
    // ------------------------------------------------------------------
    localparam logic [rpm_pkg::TICK_DIV_W-1:0] BASE_LAST =
        rpm_pkg::TICK_DIV_W'(BASE_DIV - 1);

    rpm_pkg::rpm_tick_s st_reg;   // Divider state.
    rpm_pkg::rpm_tick_s st_next;  // Next divider state.
    logic base_hit;               // Last cycle of a finest tick.
    logic [2:0] sub_mask;         // Sub-count bits that must be all ones.

    // The coarse rates are carved out of one divider so that all four share
    // a phase and a change of code takes effect within one coarse period.
    always_comb begin
        base_hit = (st_reg.base == BASE_LAST);
        sub_mask = 3'h7 >> res;
        st_next = st_reg;
        if (base_hit) begin
            st_next.base = '0;
            st_next.sub = 3'(st_reg.sub + 3'h1);
        end else begin
            st_next.base = rpm_pkg::TICK_DIV_W'(st_reg.base + 1'b1);
        end
        tick = base_hit && ((st_reg.sub & sub_mask) == sub_mask);
    end

    // Divider restarts at reset.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    tick_spacing_a: assert property (
        @(posedge clk) disable iff (!rst_n) tick |=> !tick [*8])
        else $error("Ticks closer than nine cycles.");

    fine_rate_a: assert property (
        @(posedge clk) disable iff (!rst_n) (res == 2'h3 && base_hit) |-> tick)
        else $error("Finest resolution missed a tick.");

endmodule : rpm_tick_gen

`default_nettype wire

// [rpm_meter.sv]
// Ring detector and pulse period measure unit with an APB register port.
`default_nettype none


module rpm_meter #(
    parameter int unsigned TICK_BASE_DIV = rpm_pkg::TICK_FINE_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic ring_in
);

    // ------------------------------------------------------------------
    // Declarations.
    // ------------------------------------------------------------------
    rpm_pkg::rpm_state_s st_reg;   // Whole core state.
    rpm_pkg::rpm_state_s st_next;  // Next core state.
    logic level_sync;              // Ring level after two flip-flops.
    logic tick;                    // One-cycle measurement tick.
    logic [9:0] idx;               // Word index of the bus address.
    logic mapped;                  // Bus address names a register.
    logic wr_en;                   // Write taking effect this cycle.
    logic rd_setup;                // Read setup cycle: load read data.
    logic rise;                    // Rising edge of the synced level.
    logic fall;                    // Falling edge of the synced level.
    logic evt;                     // Interrupt event this cycle.
    logic hold_wr;                 // Write to the hold register.
    logic capture;                 // Event is allowed to refresh the result.

    // ------------------------------------------------------------------
    // Input conditioning and tick generation.
    // ------------------------------------------------------------------
    // The ring pin is asynchronous to pclk, so it is synchronised first.
    rpm_sync u_sync (
        .clk(pclk),
        .rst_n(presetn),
        .async_in(ring_in),
        .sync_out(level_sync)
    );

    // Tick rate follows the resolution field of the control register.
    rpm_tick_gen #(
        .BASE_DIV(TICK_BASE_DIV)
    ) u_tick (
        .clk(pclk),
        .rst_n(presetn),
        .res(st_reg.res),
        .tick(tick)
    );

    // ------------------------------------------------------------------
    // Bus decode.
    // ------------------------------------------------------------------
    // The slave never inserts wait states, so pready is tied high and every
    // access completes in its first access cycle.
    assign pready = 1'b1;
    assign idx = rpm_pkg::reg_index(paddr);
    assign mapped = rpm_pkg::reg_mapped(paddr);
    // Unmapped or misaligned addresses answer with an error.
    assign pslverr = psel && penable && !mapped;
    // All writable registers sit in byte lane 0; a write without that lane is ignored.
    assign wr_en = psel && penable && pwrite && mapped && pstrb[0];
    assign rd_setup = psel && !penable && !pwrite;
    assign hold_wr = wr_en && (idx == rpm_pkg::IDX_HOLD);

    // ------------------------------------------------------------------
    // Next-state logic.
    // ------------------------------------------------------------------
    // Edge detection, counting, capture, registers and read data are all
    // computed here; register writes, except the hold re-arm, are applied before
    // hardware events so that an event in the same cycle always wins over a software clear.
    always_comb begin
        st_next = st_reg;
        st_next.level_prev = level_sync;

        // Edges of the synchronised level.
        rise = level_sync && !st_reg.level_prev;
        fall = !level_sync && st_reg.level_prev;

        // Events need the enable bit and a selected edge.
        evt = st_reg.enable &&
            ((st_reg.sel[0] && fall) ||
             (st_reg.sel[1] && rise));

        // Register writes.
        if (wr_en) begin
            case (idx)
                rpm_pkg::IDX_CONTROL: begin
                    st_next.enable = pwdata[rpm_pkg::CTRL_EN_BIT];
                    st_next.res = pwdata[rpm_pkg::CTRL_RES_LSB +: 2];
                    st_next.sel = pwdata[rpm_pkg::CTRL_SEL_LSB +: 2];
                end
                rpm_pkg::IDX_HOLD: begin
                    st_next.hold = pwdata[rpm_pkg::HOLD_BIT];
                end
                rpm_pkg::IDX_IRQ_STATUS: begin
                    // Writing a one clears the flag.
                    if (pwdata[rpm_pkg::IRQ_EVENT_BIT]) begin
                        st_next.status = 1'b0;
                    end
                end
                rpm_pkg::IDX_IRQ_MASK: begin
                    st_next.mask = pwdata[rpm_pkg::IRQ_EVENT_BIT];
                end
                default: begin
                    // Read-only registers ignore writes.
                end
            endcase
        end

        // Capture uses the count reached before this event clears it.
        capture = evt && (!st_reg.hold || st_reg.armed);
        if (capture) begin
            st_next.result = st_reg.count;
        end

        // In hold mode a capture disarms until software writes the hold
        // register again; the write re-arms even in the event's own cycle.
        if (evt && st_reg.hold) begin
            st_next.armed = 1'b0;
        end
        if (hold_wr) begin
            st_next.armed = 1'b1;
        end

        // Interval counter: cleared by an event, otherwise counts ticks and
        // sticks at its maximum so that over-long gaps read as full scale.
        if (evt) begin
            st_next.count = '0;
        end else if (tick && (st_reg.count != rpm_pkg::COUNT_MAX)) begin
            st_next.count = 16'(st_reg.count + 16'h0001);
        end

        // Sticky event flag; setting wins over a clear in the same cycle.
        if (evt) begin
            st_next.status = 1'b1;
        end

        // Read data is loaded in the setup cycle and shown in the access.
        if (rd_setup) begin
            st_next.prdata = rpm_pkg::RDATA_RESET;
            case (idx)
                rpm_pkg::IDX_CONTROL: begin
                    st_next.prdata[rpm_pkg::CTRL_EN_BIT] = st_reg.enable;
                    st_next.prdata[rpm_pkg::CTRL_RES_LSB +: 2] = st_reg.res;
                    st_next.prdata[rpm_pkg::CTRL_SEL_LSB +: 2] = st_reg.sel;
                end
                rpm_pkg::IDX_LEVEL: begin
                    st_next.prdata[rpm_pkg::LEVEL_BIT] = level_sync;
                end
                rpm_pkg::IDX_RESULT: begin
                    st_next.prdata[15:0] = st_reg.result;
                end
                rpm_pkg::IDX_HOLD: begin
                    st_next.prdata[rpm_pkg::HOLD_BIT] = st_reg.hold;
                end
                rpm_pkg::IDX_IRQ_STATUS: begin
                    st_next.prdata[rpm_pkg::IRQ_EVENT_BIT] = st_reg.status;
                end
                rpm_pkg::IDX_IRQ_MASK: begin
                    st_next.prdata[rpm_pkg::IRQ_EVENT_BIT] = st_reg.mask;
                end
                default: begin
                    // Unmapped reads return zero.
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register.
    // ------------------------------------------------------------------
    // Only constants are loaded under reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= rpm_pkg::STATE_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------------
    assign prdata = st_reg.prdata;
    // Level interrupt, high while the unmasked flag is set.
    assign irq = st_reg.status && st_reg.mask;

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    fall_event_a: assert property (
        (st_reg.enable && st_reg.sel[0] && !level_sync && st_reg.level_prev)
        |=> st_reg.status && st_reg.count == 16'h0000)
        else $error("Falling edge raised no event.");

    rise_event_a: assert property (
        (st_reg.enable && st_reg.sel[1] && level_sync && !st_reg.level_prev)
        |=> st_reg.status && st_reg.count == 16'h0000)
        else $error("Rising edge raised no event.");

    no_select_a: assert property (
        (st_reg.sel == 2'h0) |-> !evt)
        else $error("Event raised with no edge selected.");

    disabled_quiet_a: assert property (
        !st_reg.enable |-> !evt)
        else $error("Event raised while detection disabled.");

    count_step_a: assert property (
        (tick && !evt && st_reg.count != 16'hffff)
        |=> st_reg.count == 16'($past(st_reg.count) + 16'h0001))
        else $error("Counter did not step on a tick.");

    count_sat_a: assert property (
        (st_reg.count == 16'hffff && !evt) |=> st_reg.count == 16'hffff)
        else $error("Counter wrapped past its maximum.");

    free_capture_a: assert property (
        (evt && !st_reg.hold) |=> st_reg.result == $past(st_reg.count))
        else $error("Event did not refresh the result.");

    held_result_a: assert property (
        (evt && st_reg.hold && !st_reg.armed) |=> $stable(st_reg.result))
        else $error("Held result changed without a hold write.");

    // An armed event under hold must capture, whether it is the first event
    // after hold was set or the first one after a re-arming hold write.
    rearm_capture_a: assert property (
        (evt && st_reg.hold && st_reg.armed) |=> st_reg.result == $past(st_reg.count))
        else $error("First event after hold write did not capture.");

    level_read_a: assert property (
        (rd_setup && idx == rpm_pkg::IDX_LEVEL) |=> prdata[0] == $past(level_sync))
        else $error("Level register does not follow the input.");

endmodule : rpm_meter

`default_nettype wire

// [rpm_ring_line.sv]
// Model of the conditioned ringing line that drives the meter's ring input.
`default_nettype none

module rpm_ring_line (
    input wire logic clk,
    output logic ring_in
);
    timeunit 1ns;
    timeprecision 1ps;

    int cyc = 0;       // Free cycle count used to stamp each toggle.
    int stamp = 0;     // Cycle of the previous toggle.
    int last_gap = 0;  // Cycles between the last two toggles.

    initial ring_in = 1'b0;

    // Count cycles so the bench knows the true spacing of the edges.
    always @(posedge clk) begin
        cyc <= cyc + 1;
    end

    // Toggle the line n edges from now; the level then stands still.
    task automatic toggle_after(input int n);
        repeat (n) @(posedge clk);
        ring_in <= ~ring_in;
        last_gap = cyc - stamp;
        stamp = cyc;
    endtask : toggle_after

endmodule : rpm_ring_line

`default_nettype wire

// [rpm_meter_tb_top.sv]
// Self-checking testbench of the ring pulse period meter.
`default_nettype none

module rpm_meter_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int DIV = 10;  // Short tick divider keeps the run brief.
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic ring_in;
    int bad_count = 0;
    int n_tests = 0;
    logic [31:0] rv;
    logic er;
    logic lv;
    logic ex;
    logic [1:0] sv;
    int g;
    int p;

    rpm_meter #(.TICK_BASE_DIV(DIV)) rpm_meter_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .ring_in(ring_in));
    rpm_ring_line rpm_ring_line_i (.clk(pclk), .ring_in(ring_in));

    // 100 MHz clock.
    always #5 pclk = ~pclk;

    // ------------------------------------------------------------------
    // Bus and checking tasks.
    // ------------------------------------------------------------------
    // Print the counts and the verdict, then stop.
    task automatic results();
        $display("checks=%0d mismatches=%0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results

    // Compare one value; a mismatch is reported at once.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // A tick phase is unknown, so a gap of g cycles holds one of two counts.
    task automatic chk_cnt(input logic [31:0] seen, input int gap, input int per);
        int lo;
        lo = (gap - 1) / per;
        chk({31'h0, seen[31:16] == 16'h0000 && seen >= lo && seen <= lo + 1}, 32'h1);
    endtask : chk_cnt

    // One APB transfer; an edge passes first so psel is never set twice at once.
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                       input logic [3:0] st, output logic [31:0] rd, output logic err);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            bad_count++;
            results();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        logic [31:0] x;
        logic e;
        apb(1'b1, idx, d, 4'h1, x, e);
    endtask : wr

    task automatic rd(input logic [9:0] idx, output logic [31:0] d);
        logic e;
        apb(1'b0, idx, 32'h0000_0000, 4'h0, d, e);
    endtask : rd

    // Toggle the line, let it reach the status flag, read the result.
    task automatic edge_result(input int n, output logic [31:0] d);
        rpm_ring_line_i.toggle_after(n);
        repeat (6) @(posedge pclk);
        rd(rpm_pkg::IDX_RESULT, d);
    endtask : edge_result

    // ------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(rpm_pkg::IDX_CONTROL, rv);
        chk(rv, 32'h0000_0000);
        rd(rpm_pkg::IDX_HOLD, rv);
        chk(rv, 32'h0000_0000);
        rd(rpm_pkg::IDX_RESULT, rv);
        chk(rv, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0);
        // An unused word inside the block's range must be refused.
        apb(1'b0, 10'h1b3, 32'h0000_0000, 4'h0, rv, er);
        chk({31'h0, er}, 32'h1);
        wr(rpm_pkg::IDX_IRQ_MASK, 32'h0000_0001);
        // Every select code, both edge directions, then detection disabled.
        for (int s = 0; s < 5; s++) begin
            sv = (s == 4) ? 2'b11 : s[1:0];
            wr(rpm_pkg::IDX_CONTROL, {24'h0, s < 4, 5'b00011, sv});
            for (int k = 0; k < 2; k++) begin
                wr(rpm_pkg::IDX_IRQ_STATUS, 32'h0000_0001);
                rpm_ring_line_i.toggle_after(3);
                repeat (6) @(posedge pclk);
                lv = ring_in;
                ex = (s < 4) && (lv ? sv[1] : sv[0]);
                rd(rpm_pkg::IDX_LEVEL, rv);
                chk(rv, {31'h0, lv});
                rd(rpm_pkg::IDX_IRQ_STATUS, rv);
                chk(rv, {31'h0, ex});
                chk({31'h0, irq}, {31'h0, ex});
            end
        end
        // Masked event: flag set, line quiet until unmasked, cleared by a one.
        wr(rpm_pkg::IDX_CONTROL, 32'h0000_008f);
        wr(rpm_pkg::IDX_IRQ_MASK, 32'h0000_0000);
        rpm_ring_line_i.toggle_after(3);
        repeat (6) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        wr(rpm_pkg::IDX_IRQ_MASK, 32'h0000_0001);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        wr(rpm_pkg::IDX_IRQ_STATUS, 32'h0000_0001);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        // Refused writes: read-only result, and a write with no lane-0 strobe.
        rd(rpm_pkg::IDX_RESULT, rv);
        g = rv;
        wr(rpm_pkg::IDX_RESULT, 32'h0000_1234);
        apb(1'b1, rpm_pkg::IDX_CONTROL, 32'h0000_0000, 4'h0, rv, er);
        rd(rpm_pkg::IDX_RESULT, rv);
        chk(rv, g);
        rd(rpm_pkg::IDX_CONTROL, rv);
        chk(rv, 32'h0000_008f);
        // Interval measurement at each resolution code.
        for (int r = 0; r < 4; r++) begin
            p = DIV * (8 >> r);
            wr(rpm_pkg::IDX_CONTROL, {24'h0, 4'h8, r[1:0], 2'b11});
            rpm_ring_line_i.toggle_after(5 * p);
            edge_result(5 * p, rv);
            chk_cnt(rv, rpm_ring_line_i.last_gap, p);
        end
        // Without hold every event refreshes, serviced or not.
        wr(rpm_pkg::IDX_HOLD, 32'h0000_0000);
        rpm_ring_line_i.toggle_after(30);
        edge_result(60, rv);
        chk_cnt(rv, rpm_ring_line_i.last_gap, DIV);
        edge_result(40, rv);
        chk_cnt(rv, rpm_ring_line_i.last_gap, DIV);
        // Hold: first event captures, later ones only raise the flag.
        wr(rpm_pkg::IDX_HOLD, 32'h0000_0001);
        rd(rpm_pkg::IDX_HOLD, rv);
        chk(rv, 32'h0000_0001);
        rpm_ring_line_i.toggle_after(50);
        g = rpm_ring_line_i.last_gap;
        // Let the event land first, or its set would override the clear.
        repeat (6) @(posedge pclk);
        wr(rpm_pkg::IDX_IRQ_STATUS, 32'h0000_0001);
        rd(rpm_pkg::IDX_IRQ_STATUS, rv);
        chk(rv, 32'h0000_0000);
        edge_result(150, rv);
        chk_cnt(rv, g, DIV);
        rd(rpm_pkg::IDX_IRQ_STATUS, rv);
        chk(rv, 32'h0000_0001);
        wr(rpm_pkg::IDX_HOLD, 32'h0000_0001);
        edge_result(30, rv);
        chk_cnt(rv, rpm_ring_line_i.last_gap, DIV);
        results();
    end

endmodule : rpm_meter_tb_top

`default_nettype wire
